// ---- hw/dfb_fetch_master.sv ----
// display fetch bus master: fetches program words as bus master and
// raises vectored interrupts; registers on a classic wishbone slave.
// assumes bus inputs are synchronous to i_clock and active high.
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "dfb_params.svh"
module dfb_fetch_master #(
	parameter int TIMEOUT_CYCLES = `DFB_TIMEOUT_CYC,
	parameter int SETTLE_CYCLES  = `DFB_SETTLE_CYC
) (
	input  wire logic          i_clock,
	input  wire logic          i_nrst,
	// wishbone slave
	input  wire logic          i_wb_cyc,
	input  wire logic          i_wb_stb,
	input  wire logic          i_wb_we,
	input  wire logic [7:0]    i_wb_adr,
	input  wire logic [3:0]    i_wb_sel,
	input  wire logic [31:0]   i_wb_dat,
	output logic [31:0]        o_wb_dat,
	output logic               o_wb_ack,
	// shared bus
	input  wire logic          i_bus_init,
	input  wire logic          i_npg_in,
	input  wire logic          i_bg4_in,
	input  wire logic          i_ssyn,
	input  wire logic          i_bbsy,
	input  wire logic [15:0]   i_bus_data,
	output dfb_pkg::dfb_bus_ctl_t o_bus_ctl,
	output logic [15:0]        o_bus_addr,
	output logic               o_bus_addr_oe,
	output logic [15:0]        o_bus_data,
	output logic               o_bus_data_oe,
	// display side
	input  wire logic [4:0]    i_vector_straps,
	input  wire logic          i_draw_select,
	input  wire logic          i_fetch_resume,
	input  wire logic          i_irq_stop,
	input  wire logic          i_irq_pen,
	input  wire logic          i_irq_char,
	output logic [15:0]        o_word,
	output dfb_pkg::dfb_tp_t   o_tp,
	output logic               o_draw_start,
	output logic               o_bus_owned
);
	// ****************************************
	// elaboration checks
	// ****************************************
	generate
		if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 4095) begin : g_bad_tmo
			$error("dfb_fetch_master: TIMEOUT_CYCLES out of range");
		end
		if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 4095) begin : g_bad_settle
			$error("dfb_fetch_master: SETTLE_CYCLES out of range");
		end
	endgenerate

	// ****************************************
	// state
	// ****************************************
	dfb_pkg::dfb_phase_t phase_reg;
	dfb_pkg::dfb_phase_t phase_next;
	logic        fetch_req_reg;
	logic        fetch_req_next;
	logic        grant_ack_flag;
	logic        grant_ack_next;
	logic        master_claim_flag;
	logic        master_claim_next;
	logic        intr_grant_reg;
	logic        intr_grant_next;
	logic        fetch_timeout_flag;
	logic        timeout_next;
	logic        stop_reg;
	logic        stop_next;
	logic        pen_reg;
	logic        pen_next;
	logic        char_reg;
	logic        char_next;
	logic        data_seen_reg;
	logic        data_seen_next;
	logic [15:0] display_program_counter;
	logic [15:0] pc_next;
	logic        inhibit_reg;
	logic [2:0]  level_reg;
	logic [4:0]  strap_reg;
	logic [31:0] rdata_next;
	dfb_pkg::dfb_bus_ctl_t ctl_next;

	// ****************************************
	// wishbone decode
	// ****************************************
	wire wb_req   = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	wire wb_wr    = wb_req & i_wb_we;
	wire hit_pc   = i_wb_adr == `DFB_OFF_PC;
	wire hit_ctrl = i_wb_adr == `DFB_OFF_CTRL;
	wire hit_stat = i_wb_adr == `DFB_OFF_STATUS;
	wire hit_word = i_wb_adr == `DFB_OFF_WORD;
	// odd program addresses are refused outright
	wire fetch_start_strobe = wb_wr & hit_pc & (&i_wb_sel[1:0]) & ~i_wb_dat[0];
	wire ctrl_wr  = wb_wr & hit_ctrl & i_wb_sel[0];

	// ****************************************
	// bus handshake terms
	// ****************************************
	wire level4   = level_reg == `DFB_LEVEL_FOUR;
	wire bus_own  = grant_ack_flag & master_claim_flag;
	wire in_wait  = phase_reg == dfb_pkg::DFB_PH_WAIT;
	wire in_intr  = phase_reg == dfb_pkg::DFB_PH_INTR;
	wire settle_done;
	wire tmo_expired;
	wire fetch_data_ready   = in_wait & i_ssyn & ~data_seen_reg;
	wire timeout_set        = in_wait & tmo_expired & ~data_seen_reg;
	wire interrupt_complete = in_intr & i_ssyn;
	// load pulse and timeout both free the bus
	wire request_clear = o_tp.load_pulse | timeout_set | i_bus_init;
	wire final_time_pulse = o_tp.tp2;
	wire refetch = final_time_pulse & ~i_draw_select & ~inhibit_reg;

	// character and timeout share vector 330 and rank first
	wire sel_tmo  = fetch_timeout_flag | char_reg;
	wire sel_pen  = ~sel_tmo & pen_reg;
	wire sel_stop = ~sel_tmo & ~pen_reg;
	wire pending  = fetch_timeout_flag | char_reg | pen_reg | stop_reg;
	wire [3:0] vec_low = sel_tmo ? `DFB_VEC_LOW_TMO :
		sel_pen ? `DFB_VEC_LOW_PEN : `DFB_VEC_LOW_STOP;
	wire strap_ok = strap_reg == `DFB_STRAP_OK;
	wire done_clr = interrupt_complete | i_bus_init;

	wire npg_take = i_npg_in & fetch_req_reg & ~grant_ack_flag;
	wire bg_take  = i_bg4_in & level4 & pending & ~grant_ack_flag
		& ~fetch_req_reg;
	// the grant must be gone before claiming, which is the arbiter's part
	wire claim_ok = grant_ack_flag & ~master_claim_flag & ~i_npg_in
		& ~i_bg4_in & ~i_ssyn & ~i_bbsy;
	wire grant_clr = i_bus_init | (request_clear & ~intr_grant_reg)
		| interrupt_complete;

	// ****************************************
	// flag next values; a set beats a clear, except master_claim_next, where grant_clr wins
	// ****************************************
	assign fetch_req_next = (fetch_start_strobe | refetch | i_fetch_resume) ? 1'b1 :
		request_clear ? 1'b0 : fetch_req_reg;
	assign grant_ack_next = (npg_take | bg_take) ? 1'b1 :
		grant_clr ? 1'b0 : grant_ack_flag;
	assign master_claim_next = grant_clr ? 1'b0 :
		claim_ok ? 1'b1 : master_claim_flag;
	assign intr_grant_next = bg_take ? 1'b1 :
		grant_clr ? 1'b0 : intr_grant_reg;
	assign timeout_next = timeout_set ? 1'b1 :
		(done_clr & (sel_tmo | i_bus_init)) ? 1'b0 : fetch_timeout_flag;
	assign char_next = i_irq_char ? 1'b1 :
		(done_clr & (sel_tmo | i_bus_init)) ? 1'b0 : char_reg;
	assign pen_next = i_irq_pen ? 1'b1 :
		(done_clr & (sel_pen | i_bus_init)) ? 1'b0 : pen_reg;
	assign stop_next = i_irq_stop ? 1'b1 :
		(done_clr & (sel_stop | i_bus_init)) ? 1'b0 : stop_reg;
	assign data_seen_next = fetch_data_ready ? 1'b1 :
		(phase_next != dfb_pkg::DFB_PH_WAIT) ? 1'b0 : data_seen_reg;

	// program counter: start loads it, tp1 steps to the next word
	assign pc_next = fetch_start_strobe ? i_wb_dat[15:0] :
		o_tp.tp1 ? display_program_counter + `DFB_PC_STEP :
		display_program_counter;

	// ****************************************
	// bus cycle phase
	// ****************************************
	always_comb begin
		phase_next = phase_reg;
		unique case (phase_reg)
			dfb_pkg::DFB_PH_IDLE: begin
				if (bus_own && intr_grant_reg && pending)
					phase_next = dfb_pkg::DFB_PH_INTR;
				else if (bus_own && !intr_grant_reg && fetch_req_reg)
					phase_next = dfb_pkg::DFB_PH_SETTLE;
			end
			dfb_pkg::DFB_PH_SETTLE: begin
				if (settle_done)
					phase_next = dfb_pkg::DFB_PH_WAIT;
			end
			dfb_pkg::DFB_PH_WAIT: begin
				if (request_clear)
					phase_next = dfb_pkg::DFB_PH_IDLE;
			end
			dfb_pkg::DFB_PH_INTR: begin
				if (interrupt_complete)
					phase_next = dfb_pkg::DFB_PH_IDLE;
			end
		endcase
		if (i_bus_init)
			phase_next = dfb_pkg::DFB_PH_IDLE;
	end

	// ****************************************
	// settle delay and no-response timeout
	// ****************************************
	wire settle_load = phase_reg == dfb_pkg::DFB_PH_IDLE
		&& phase_next == dfb_pkg::DFB_PH_SETTLE;
	wire tmo_load = phase_reg == dfb_pkg::DFB_PH_SETTLE && settle_done;

	dfb_delay_timer #(.W(12)) u_settle (
		.i_clock   (i_clock),
		.i_nrst    (i_nrst),
		.i_load    (settle_load),
		.i_count   (12'(SETTLE_CYCLES)),
		.i_run     (phase_reg == dfb_pkg::DFB_PH_SETTLE),
		.o_expired (settle_done)
	);

	// reloaded as msyn rises, frozen once ssyn has answered
	dfb_delay_timer #(.W(12)) u_timeout (
		.i_clock   (i_clock),
		.i_nrst    (i_nrst),
		.i_load    (tmo_load),
		.i_count   (12'(TIMEOUT_CYCLES)),
		.i_run     (in_wait & ~data_seen_reg & ~i_ssyn),
		.o_expired (tmo_expired)
	);

	// word timing starts from data-ready
	dfb_word_timer u_word_timer (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_start (fetch_data_ready),
		.o_tp    (o_tp)
	);

	// ****************************************
	// bus control next values
	// ****************************************
	wire own_next = grant_ack_next & master_claim_next;
	wire pend_next = timeout_next | char_next | pen_next | stop_next;
	wire fetch_phase_next = phase_next == dfb_pkg::DFB_PH_SETTLE
		|| phase_next == dfb_pkg::DFB_PH_WAIT;
	wire intr_next = phase_next == dfb_pkg::DFB_PH_INTR;

	assign ctl_next.npr  = fetch_req_next & ~grant_ack_next & ~master_claim_next;
	assign ctl_next.sack = grant_ack_next & ~master_claim_next;
	assign ctl_next.bbsy = own_next;
	assign ctl_next.msyn = phase_next == dfb_pkg::DFB_PH_WAIT;
	assign ctl_next.br4  = pend_next & level4 & ~grant_ack_next;
	assign ctl_next.intr = intr_next;
	assign ctl_next.npg_out = i_npg_in & ~fetch_req_next & ~grant_ack_next;
	// a level other than 4 in the control register wires the grant straight through
	assign ctl_next.bg4_out = level4 ?
		(i_bg4_in & ~pend_next & ~grant_ack_next) : i_bg4_in;

	// ****************************************
	// register read mux
	// ****************************************
	assign rdata_next =
		hit_pc   ? {16'h0000, display_program_counter} :
		hit_ctrl ? {25'h0, level_reg, 3'h0, inhibit_reg} :
		hit_stat ? {22'h0, strap_ok, pending, fetch_timeout_flag,
			ctl_next.msyn, bus_own, master_claim_flag, grant_ack_flag,
			fetch_req_reg, phase_reg} :
		hit_word ? {16'h0000, o_word} : 32'h00000000;

	// ****************************************
	// flags and phase
	// ****************************************
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			phase_reg          <= dfb_pkg::DFB_PH_IDLE;
			fetch_req_reg      <= 1'b0;
			grant_ack_flag     <= 1'b0;
			master_claim_flag  <= 1'b0;
			intr_grant_reg     <= 1'b0;
			fetch_timeout_flag <= 1'b0;
			char_reg           <= 1'b0;
			pen_reg            <= 1'b0;
			stop_reg           <= 1'b0;
			data_seen_reg      <= 1'b0;
		end else begin
			phase_reg          <= phase_next;
			fetch_req_reg      <= fetch_req_next;
			grant_ack_flag     <= grant_ack_next;
			master_claim_flag  <= master_claim_next;
			intr_grant_reg     <= intr_grant_next;
			fetch_timeout_flag <= timeout_next;
			char_reg           <= char_next;
			pen_reg            <= pen_next;
			stop_reg           <= stop_next;
			data_seen_reg      <= data_seen_next;
		end
	end

	// ****************************************
	// software registers and straps
	// ****************************************
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			display_program_counter <= `DFB_PC_RESET;
			inhibit_reg <= 1'b0;
			level_reg   <= `DFB_LEVEL_RESET;
			strap_reg   <= 5'h00;
			o_word      <= 16'h0000;
		end else begin
			display_program_counter <= pc_next;
			if (ctrl_wr) begin
				inhibit_reg <= i_wb_dat[`DFB_CTRL_INHIBIT];
				level_reg   <= i_wb_dat[`DFB_CTRL_LEVEL_HI:`DFB_CTRL_LEVEL_LO];
			end
			// straps are static jumpers, resampled on every clock after reset release
			strap_reg <= i_vector_straps;
			if (fetch_data_ready)
				o_word <= i_bus_data;
		end
	end

	// ****************************************
	// registered outputs
	// ****************************************
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_wb_ack      <= 1'b0;
			o_wb_dat      <= 32'h00000000;
			o_bus_ctl     <= '0;
			o_bus_addr    <= 16'h0000;
			o_bus_addr_oe <= 1'b0;
			o_bus_data    <= 16'h0000;
			o_bus_data_oe <= 1'b0;
			o_draw_start  <= 1'b0;
			o_bus_owned   <= 1'b0;
		end else begin
			o_wb_ack      <= wb_req;
			o_wb_dat      <= wb_req ? rdata_next : 32'h00000000;
			o_bus_ctl     <= ctl_next;
			o_bus_addr    <= pc_next;
			o_bus_addr_oe <= own_next & fetch_phase_next;
			o_bus_data    <= {7'h00, strap_reg, vec_low};
			o_bus_data_oe <= intr_next & strap_ok;
			o_draw_start  <= final_time_pulse & i_draw_select;
			o_bus_owned   <= own_next;
		end
	end
endmodule : dfb_fetch_master

// ---- pkg/dfb_params.svh ----
// constants of the display fetch bus master: offsets, fields, resets, timing
// assumes a 32-bit classic wishbone slave port and a 10 MHz clock
`ifndef DFB_PARAMS_SVH
`define DFB_PARAMS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define DFB_OFF_PC     8'h00
`define DFB_OFF_CTRL   8'h04
`define DFB_OFF_STATUS 8'h08
`define DFB_OFF_WORD   8'h0C

// ****************************************
// fields and reset values
// ****************************************
`define DFB_CTRL_INHIBIT   0
`define DFB_CTRL_LEVEL_LO  4
`define DFB_CTRL_LEVEL_HI  6
`define DFB_LEVEL_RESET    3'h4
`define DFB_LEVEL_FOUR     3'h4
`define DFB_PC_RESET       16'h0000
`define DFB_PC_STEP        16'h0002
`define DFB_STRAP_OK       5'h0D
`define DFB_VEC_LOW_STOP   4'h0
`define DFB_VEC_LOW_PEN    4'h4
`define DFB_VEC_LOW_TMO    4'h8

// ****************************************
// timing
// ****************************************
`define DFB_CLK_MHZ        10
`define DFB_SETTLE_NS      100
`define DFB_TIMEOUT_NS     22000
`define DFB_SETTLE_CYC     ((`DFB_SETTLE_NS * `DFB_CLK_MHZ + 999) / 1000)
`define DFB_TIMEOUT_CYC    ((`DFB_TIMEOUT_NS * `DFB_CLK_MHZ + 999) / 1000)

`endif

// ---- pkg/dfb_pkg.sv ----
// types of the display fetch bus master
// assumes the constants header sits beside it
package dfb_pkg;

	// ****************************************
	// bus cycle phase, gray along idle-settle-wait
	// ****************************************
	typedef enum logic [1:0] {
		DFB_PH_IDLE   = 2'h0,
		DFB_PH_SETTLE = 2'h1,
		DFB_PH_WAIT   = 2'h3,
		DFB_PH_INTR   = 2'h2
	} dfb_phase_t;

	// bus control lines, high means asserted on the bus
	typedef struct packed {
		logic npr;
		logic sack;
		logic bbsy;
		logic msyn;
		logic br4;
		logic intr;
		logic npg_out;
		logic bg4_out;
	} dfb_bus_ctl_t;

	// per-word timing pulses
	typedef struct packed {
		logic load_mode;
		logic load_pulse;
		logic tp1;
		logic tp2;
	} dfb_tp_t;

endpackage : dfb_pkg

// ---- hw/dfb_delay_timer.sv ----
// down-counting delay: loaded with a count, expires when it runs out
// assumes load and run come from synchronous logic
`timescale 1ns/1ps
module dfb_delay_timer #(
	parameter int W = 12
) (
	input  wire logic         i_clock,
	input  wire logic         i_nrst,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_count,
	input  wire logic         i_run,
	output logic              o_expired
);
	logic [W-1:0] cnt_reg;

	generate
		if (W < 2) begin : g_bad
			$error("dfb_delay_timer: W too small");
		end
	endgenerate

	// ****************************************
	// counter
	// ****************************************
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			cnt_reg   <= '0;
			o_expired <= 1'b0;
		end else begin
			if (i_load)
				cnt_reg <= i_count;
			else if (i_run && cnt_reg != '0)
				cnt_reg <= cnt_reg - 1'b1;
			// single pulse as the last count drains
			o_expired <= i_run && !i_load && cnt_reg == {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule : dfb_delay_timer

// ---- hw/dfb_word_timer.sv ----
// per-word timing: one start gives load_mode, load_pulse, tp1, tp2 in turn
// assumes start pulses are at least four cycles apart
`timescale 1ns/1ps
module dfb_word_timer (
	input  wire logic     i_clock,
	input  wire logic     i_nrst,
	input  wire logic     i_start,
	output dfb_pkg::dfb_tp_t o_tp
);
	logic [2:0] step_reg;
	logic [2:0] step_next;

	// steps 1..4 each raise one pulse, 0 is quiescent
	assign step_next = i_start ? 3'h1 :
		(step_reg != 3'h0 && step_reg != 3'h4) ? step_reg + 3'h1 : 3'h0;

	// ****************************************
	// step register and pulse decode
	// ****************************************
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			step_reg <= 3'h0;
			o_tp     <= '0;
		end else begin
			step_reg        <= step_next;
			o_tp.load_mode  <= step_next == 3'h1;
			o_tp.load_pulse <= step_next == 3'h2;
			o_tp.tp1        <= step_next == 3'h3;
			o_tp.tp2        <= step_next == 3'h4;
		end
	end
endmodule : dfb_word_timer

// ---- sim/dfb_fetch_master_asserts.sv ----
// checker of the fetch master bus handshake, bound to the top module
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module dfb_fetch_master_asserts #(
	parameter int TIMEOUT_CYCLES = 8
) (
	input wire logic                  i_clock,
	input wire logic                  i_nrst,
	input wire logic                  i_npg_in,
	input wire logic                  i_ssyn,
	input wire logic                  i_bbsy,
	input wire dfb_pkg::dfb_bus_ctl_t o_bus_ctl,
	input wire logic                  o_bus_addr_oe,
	input wire logic                  o_bus_owned,
	input wire logic [15:0]           o_bus_data,
	input wire logic                  o_bus_data_oe,
	input wire dfb_pkg::dfb_tp_t      o_tp
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	int wait_cnt;
	// msyn cycles with no answer; an overflow means the timeout never fired
	always_ff @(posedge i_clock) begin
		if (!i_nrst || !o_bus_ctl.msyn || i_ssyn) begin
			wait_cnt <= 0;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	// pulses that follow the mode strobe of each word
	sequence s_word_tail;
		o_tp.load_pulse ##1 o_tp.tp1 ##1 o_tp.tp2;
	endsequence
	// ****************************************
	// assertions
	// ****************************************
	a_ssyn_ready: assert property ($rose(i_ssyn) && o_bus_ctl.msyn |-> ##1 o_tp.load_mode)
		else $error("word timing did not start after ssyn");
	a_word_pulses: assert property (o_tp.load_mode |=> s_word_tail)
		else $error("timing pulses out of order");
	a_grant_ack: assert property (i_npg_in && o_bus_ctl.npr |=> o_bus_ctl.sack && !o_bus_ctl.npr)
		else $error("grant not acknowledged");
	a_grant_kept: assert property (o_bus_ctl.sack |-> !o_bus_ctl.npg_out && !o_bus_ctl.npr)
		else $error("grant passed on or npr held with sack");
	a_claim_idle: assert property ($rose(o_bus_ctl.bbsy) |-> !$past(i_npg_in) && !$past(i_ssyn) && !$past(i_bbsy))
		else $error("bus claimed while busy");
	a_owned_bbsy: assert property (o_bus_owned |-> o_bus_ctl.bbsy)
		else $error("owned without bbsy");
	a_addr_owned: assert property (o_bus_addr_oe |-> o_bus_owned && !o_bus_ctl.intr)
		else $error("address driven without ownership");
	a_msyn_settle: assert property ($rose(o_bus_ctl.msyn) |-> $past(o_bus_addr_oe) && $past(o_bus_addr_oe, 2))
		else $error("msyn before address settled");
	a_load_frees: assert property (o_tp.load_pulse && o_bus_ctl.msyn |=> !o_bus_ctl.msyn && !o_bus_ctl.bbsy)
		else $error("bus kept after load pulse");
	a_wait_bound: assert property (wait_cnt <= TIMEOUT_CYCLES + 2)
		else $error("msyn outlived the timeout");
	a_vector_straps: assert property (o_bus_data_oe |-> o_bus_ctl.intr && o_bus_data[8:4] == 5'h0D)
		else $error("vector driven with wrong straps");
	a_intr_done: assert property (o_bus_ctl.intr && i_ssyn |=> !o_bus_ctl.intr && !o_bus_data_oe)
		else $error("interrupt not ended by ssyn");
	a_bg4_block: assert property (o_bus_ctl.br4 |-> !o_bus_ctl.bg4_out)
		else $error("level 4 grant passed while requesting");
endmodule : dfb_fetch_master_asserts

bind dfb_fetch_master dfb_fetch_master_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
	.i_clock(i_clock), .i_nrst(i_nrst), .i_npg_in(i_npg_in), .i_ssyn(i_ssyn),
	.i_bbsy(i_bbsy), .o_bus_ctl(o_bus_ctl), .o_bus_addr_oe(o_bus_addr_oe),
	.o_bus_owned(o_bus_owned), .o_bus_data(o_bus_data), .o_bus_data_oe(o_bus_data_oe),
	.o_tp(o_tp));

// ---- sim/dfb_bus_partner.sv ----
// bus partner: arbiter for npr and level 4, memory, and processor slave
// assumes active-high bus levels; every output changes at the rising edge
`timescale 1ns/1ps
module dfb_bus_partner (
	input  wire logic                  i_clock,
	input  wire logic                  i_nrst,
	input  wire dfb_pkg::dfb_bus_ctl_t i_ctl,
	input  wire logic [15:0]           i_addr,
	input  wire logic                  i_mute,
	input  wire logic                  i_bg4_force,
	output logic                       o_npg,
	output logic                       o_bg4,
	output logic                       o_ssyn,
	output logic [15:0]                o_data
);
	logic [2:0] lat_cnt;
	logic       answer;
	// memory answers two cycles into msyn; a muted memory stays silent
	assign answer = i_ctl.msyn && !i_mute && lat_cnt == 3'h2;
	// grants are withdrawn once sack is seen, except bg4 while i_bg4_force holds it
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_npg   <= 1'b0;
			o_bg4   <= 1'b0;
			o_ssyn  <= 1'b0;
			lat_cnt <= 3'h0;
			o_data  <= 16'h0000;
		end else begin
			o_npg   <= i_ctl.npr && !i_ctl.sack;
			o_bg4   <= (i_ctl.br4 && !i_ctl.sack) || i_bg4_force;
			lat_cnt <= i_ctl.msyn ? lat_cnt + 3'h1 : 3'h0;
			o_ssyn  <= answer || (o_ssyn && i_ctl.msyn) || i_ctl.intr;
			// word goes out before ssyn; released lines flip so stale data cannot pass
			if (i_ctl.msyn && !i_mute && lat_cnt != 3'h0) begin
				o_data <= {i_addr[7:0], i_addr[15:8]};
			end else begin
				o_data <= ~o_data;
			end
		end
	end
endmodule : dfb_bus_partner

// ---- sim/tb_dfb_fetch_master.sv ----
// bench of the fetch master against the bus partner model
// assumes the partner answers memory reads and interrupt vectors
`timescale 1ns/1ps
`include "dfb_params.svh"
module tb_dfb_fetch_master;
	localparam int TMO = 8;
	localparam int NPR = 7, MSYN = 4, BR4 = 3, INTR = 2;
	logic                  i_clock, i_nrst, cyc, stb, we, ack, init, npg, bg4, ssyn;
	logic                  oe_a, oe_d, owned, draw, resume, mute, bg4f, dstart, pen, stp;
	logic                  busy, chr;
	logic [7:0]            adr;
	logic [31:0]           wdat, rdat, wbo;
	logic [15:0]           mdat, addr, vdat, word;
	logic [4:0]            straps;
	dfb_pkg::dfb_bus_ctl_t ctl;
	dfb_pkg::dfb_tp_t      tp;
	int                    err_count, checks, n;

	dfb_fetch_master #(.TIMEOUT_CYCLES(TMO)) DUT (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(wbo), .o_wb_ack(ack),
		.i_bus_init(init), .i_npg_in(npg), .i_bg4_in(bg4), .i_ssyn(ssyn), .i_bbsy(busy),
		.i_bus_data(mdat), .o_bus_ctl(ctl), .o_bus_addr(addr), .o_bus_addr_oe(oe_a),
		.o_bus_data(vdat), .o_bus_data_oe(oe_d), .i_vector_straps(straps),
		.i_draw_select(draw), .i_fetch_resume(resume), .i_irq_stop(stp), .i_irq_pen(pen),
		.i_irq_char(chr), .o_word(word), .o_tp(tp), .o_draw_start(dstart),
		.o_bus_owned(owned));
	dfb_bus_partner u_far (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_ctl(ctl), .i_addr(addr), .i_mute(mute),
		.i_bg4_force(bg4f), .o_npg(npg), .o_bg4(bg4), .o_ssyn(ssyn), .o_data(mdat));

	always #50 i_clock = ~i_clock;

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic tick(input int k);
		repeat (k) @(posedge i_clock);
	endtask : tick
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic bound(input int k, input int lim);
		if (k >= lim) begin
			err_count++;
			$display("wrong value at %0t: wait ran out", $time);
			finish_test();
		end
	endtask : bound
	// classic cycle: held until ack is sampled, data taken at that edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge i_clock);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge i_clock);
		rdat = wbo;
		{cyc, stb} <= 2'b00;
		bound(k, 20);
	endtask : wb
	task automatic wait_ctl(input int b, input logic v);
		for (n = 0; n < 80 && ctl[b] !== v; n++) @(posedge i_clock);
		bound(n, 80);
	endtask : wait_ctl
	// one whole fetch, address watched on every cycle it is driven
	task automatic fetch_word(input logic [15:0] a);
		@(posedge i_clock);
		for (n = 0; n < 60 && tp.load_pulse !== 1'b1; n++) begin
			@(posedge i_clock);
			if (oe_a === 1'b1) check(addr, a, "fetch address");
		end
		bound(n, 60);
		check(word, {a[7:0], a[15:8]}, "fetched word");
	endtask : fetch_word
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		wb(1'b1, `DFB_OFF_PC, 32'h1235);
		tick(6);
		check(ctl.npr | ctl.sack | ctl.bbsy, 1'b0, "odd address started a fetch");
		wb(1'b0, `DFB_OFF_PC, 32'h0);
		check(rdat, 32'h0, "odd address loaded");
		wb(1'b0, `DFB_OFF_CTRL, 32'h0);
		check(rdat, 32'h40, "control reset value");
		wb(1'b0, 8'h40, 32'h0);
		check(rdat, 32'h0, "unmapped read");
		$display("test regs done");
	endtask : t_regs
	task automatic t_fetch();
		wb(1'b1, `DFB_OFF_PC, 32'h0100);
		fetch_word(16'h0100);
		fetch_word(16'h0102);
		wait_ctl(NPR, 1'b1);
		wb(1'b1, `DFB_OFF_CTRL, 32'h41);
		fetch_word(16'h0104);
		tick(3);
		check(ctl.npr, 1'b0, "inhibited word fetched again");
		tick(9);
		check(ctl.bbsy | ctl.msyn, 1'b0, "bus kept after word");
		wb(1'b1, `DFB_OFF_CTRL, 32'h40);
		draw <= 1'b1;
		wb(1'b1, `DFB_OFF_PC, 32'h0200);
		fetch_word(16'h0200);
		for (n = 0; n < 10 && dstart !== 1'b1; n++) @(posedge i_clock);
		bound(n, 10);
		wb(1'b1, `DFB_OFF_CTRL, 32'h41);
		check(ctl.npr, 1'b0, "draw word fetched again");
		{draw, resume} <= 2'b01;
		tick(1);
		resume <= 1'b0;
		fetch_word(16'h0202);
		$display("test fetch done");
	endtask : t_fetch
	task automatic t_intr();
		mute <= 1'b1;
		wb(1'b1, `DFB_OFF_PC, 32'h0300);
		wait_ctl(BR4, 1'b1);
		check(ctl.msyn, 1'b0, "msyn kept after timeout");
		wait_ctl(INTR, 1'b1);
		check({oe_d, vdat[8:0]}, 10'h2D8, "timeout vector");
		wait_ctl(INTR, 1'b0);
		wb(1'b0, `DFB_OFF_STATUS, 32'h0);
		check(rdat[7], 1'b0, "timeout flag kept");
		{pen, stp} <= 2'b10;
		tick(1);
		pen <= 1'b0;
		wait_ctl(INTR, 1'b1);
		check({oe_d, vdat[8:0]}, 10'h2D4, "light pen vector");
		wait_ctl(INTR, 1'b0);
		chr <= 1'b1;
		tick(1);
		chr <= 1'b0;
		wait_ctl(INTR, 1'b1);
		check({oe_d, vdat[8:0]}, 10'h2D8, "character vector");
		wait_ctl(INTR, 1'b0);
		{straps, stp} <= 6'h01;
		tick(1);
		stp <= 1'b0;
		wait_ctl(INTR, 1'b1);
		check(oe_d, 1'b0, "vector with wrong straps");
		wait_ctl(INTR, 1'b0);
		{straps, mute} <= 6'h1A;
		$display("test interrupt done");
	endtask : t_intr
	task automatic t_level();
		wb(1'b1, `DFB_OFF_CTRL, 32'h31);
		{stp, bg4f} <= 2'b11;
		tick(1);
		stp <= 1'b0;
		tick(2);
		check(ctl.bg4_out, 1'b1, "grant not passed at level 3");
		check(ctl.br4, 1'b0, "level 4 request at level 3");
		bg4f <= 1'b0;
		wb(1'b1, `DFB_OFF_CTRL, 32'h41);
		wait_ctl(INTR, 1'b1);
		check({oe_d, vdat[8:0]}, 10'h2D0, "stop vector");
		wait_ctl(INTR, 1'b0);
		$display("test level done");
	endtask : t_level
	task automatic t_init();
		{mute, busy} <= 2'b11;
		wb(1'b1, `DFB_OFF_PC, 32'h0400);
		tick(8);
		check({ctl.sack, ctl.bbsy}, 2'b10, "bus claimed while busy");
		busy <= 1'b0;
		wait_ctl(MSYN, 1'b1);
		init <= 1'b1;
		tick(2);
		check({ctl, oe_a, owned}, 10'h0, "bus state after init");
		{init, mute} <= 2'b00;
		$display("test init done");
	endtask : t_init

	initial begin
		{i_clock, i_nrst, cyc, stb, we, init, draw, resume, mute, bg4f, pen, stp, busy, chr} = 14'h0;
		{adr, wdat, straps} = {8'h00, 32'h0, 5'h0D};
		err_count = 0;
		checks = 0;
		tick(3);
		i_nrst <= 1'b1;
		t_regs();
		t_fetch();
		t_intr();
		t_level();
		t_init();
		finish_test();
	end
endmodule : tb_dfb_fetch_master
